/* src/spi_buf_map.vh */
// register offsets, field positions and reset values of the serial port block
`ifndef SPI_BUF_MAP_VH
`define SPI_BUF_MAP_VH
`define CTRL_OFS 12'h000
`define STAT_OFS 12'h004
`define DATA_OFS 12'h008
`define CTRL_TX_IRQ_EN 0
`define CTRL_MOD_EN 1
`define CTRL_PHASE 2
`define CTRL_POL 3
`define CTRL_ROLE 4
`define STAT_ERR_IRQ_EN 0
`define STAT_CONF_EN 1
`define STAT_OVR 4
`define STAT_CONF 5
`define STAT_TXE 6
`define STAT_RXF 7
`define CTRL_RESET 5'h00
`define BUS_CYCLE_NS 8
`define BIT_HALF_NS 64
`define HALF_CYCLES (`BIT_HALF_NS / `BUS_CYCLE_NS)
`endif

/* src/spi_buffering.v */
// byte-wide serial port: transmit queue, receive flag, overrun and select-conflict logic
//
// Function
// RULE1: master starts queued byte right after previous
// RULE2: data write clears tx empty; load sets it
// RULE3: byte end moves shifter to rx buffer
// RULE4: rx full cleared by status read then data read
// RULE5: without new byte, old shifter contents resend
// RULE6: idle load sets tx empty within two cycles
// RULE7: busy slave defers shifter load until done
// RULE8: overrun set at bit one strobe if unread
// RULE9: overrun blocks new bytes, keeps old byte
// RULE10: overrun cleared by status read then data read
// RULE11: error enable routes overrun/conflict to error irq
// RULE12: role bit sets clock and data pin directions
// RULE13: conflict flag sets only while its enable set
// RULE14: master sets conflict when select goes low
// RULE15: master conflict disables, sets tx empty, clears counter
// RULE16: slave sets conflict if select rises mid-transfer
// RULE17: slave transfer bounds depend on clock phase
// RULE18: phase 0 select pulse alone flags conflict
// RULE19: slave conflict keeps enable and slave state
// RULE20: conflict leaves role bit; role ignored when disabled
// RULE21: deselected slave floats data out, ignores clock
// RULE22: conflict cleared by status read then control write
// RULE23: tx irq needs tx enable and module enable
// RULE24: software writes data only when tx empty
`timescale 1ns/1ps
`default_nettype none
`include "spi_buf_map.vh"
module spi_buffering #(
  parameter HALF_CYCLES = `HALF_CYCLES
) (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // serial pins, three signals each for the shared lines
  input wire serial_clock_pin_in,
  output reg serial_clock_pin_out,
  output reg serial_clock_pin_oe,
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe,
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe,
  input wire select_n_in,
  // interrupt requests
  output reg tx_irq,
  output reg rx_err_irq
);
  // control and status storage
  reg tx_irq_enable_reg, module_enable_reg, clock_phase_sel_reg, clock_polarity_sel_reg, role_select_bit_reg;
  reg error_irq_enable_reg, select_conflict_enable_reg, rx_irq_enable_reg;
  reg tx_empty_flag_reg, rx_full_flag_reg, overrun_flag_reg, select_conflict_flag_reg;
  reg [7:0] tx_buf_reg, shift_reg, rx_buf_reg;
  reg [3:0] bit_cnt_reg;
  reg busy_reg, phase_reg, rx_armed_reg, ovr_armed_reg, conf_armed_reg;
  reg rx_bit_reg;
  reg [7:0] div_reg;
  reg sck_int_reg;
  // pin synchronisers, second stage of each pin
  wire [3:0] pin_sync;
  reg sck_d_reg, ss_d_reg;

  // decode used by both the write and read paths
  function is_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      is_hit = (a[11:2] == ofs[11:2]);
    end
  endfunction

  wire access = psel & penable;
  wire wr_ctrl = access & pwrite & is_hit(paddr, `CTRL_OFS);
  wire wr_stat = access & pwrite & is_hit(paddr, `STAT_OFS);
  wire wr_data = access & pwrite & is_hit(paddr, `DATA_OFS);
  wire rd_stat = access & ~pwrite & is_hit(paddr, `STAT_OFS);
  wire rd_data = access & ~pwrite & is_hit(paddr, `DATA_OFS);
  wire mapped = is_hit(paddr, `CTRL_OFS) | is_hit(paddr, `STAT_OFS) | is_hit(paddr, `DATA_OFS);

  // two flops on every pin input; only the second stage is looked at
  // pin order in the vector: clock, select, mosi, miso
  wire [3:0] pin_raw = {miso_in, mosi_in, select_n_in, serial_clock_pin_in};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg a_reg;
      reg b_reg;
      // select idles high; resetting its flops low would fake a select edge
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          a_reg <= (gi == 1) ? 1'b1 : 1'b0;
          b_reg <= (gi == 1) ? 1'b1 : 1'b0;
        end else begin
          a_reg <= pin_raw[gi];
          b_reg <= a_reg;
        end
      end
      assign pin_sync[gi] = b_reg;
    end
  endgenerate

  // one more stage on clock and select for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d_reg <= 1'b0;
      ss_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= pin_sync[0];
      ss_d_reg <= pin_sync[1];
    end
  end

  // synchronised clock and select, their edges and the role
  wire sck_s = pin_sync[0];
  wire ss_s = pin_sync[1];
  wire ss_fell = ss_d_reg & ~ss_s;
  wire ss_rose = ~ss_d_reg & ss_s;
  wire is_master = module_enable_reg & role_select_bit_reg; // RULE20
  wire is_slave = module_enable_reg & ~role_select_bit_reg;

  // slave clock edges, polarity folded in; select high masks them all
  wire s_lead = is_slave & ~ss_s & (sck_s ^ clock_polarity_sel_reg) & ~(sck_d_reg ^ clock_polarity_sel_reg); // RULE21
  wire s_trail = is_slave & ~ss_s & ~(sck_s ^ clock_polarity_sel_reg) & (sck_d_reg ^ clock_polarity_sel_reg); // RULE21

  // master clock from a divider; half bit period per toggle
  // the divider only runs while busy, so a start waits one half period
  wire m_tick = is_master & busy_reg & (div_reg == HALF_CYCLES - 1);
  wire m_lead = m_tick & ~phase_reg;
  wire m_trail = m_tick & phase_reg;
  wire lead = m_lead | s_lead;
  wire trail = m_trail | s_trail;

  // phase 0 samples on leading edge, phase 1 on trailing; idle edges ignored
  wire sample = busy_reg & (clock_phase_sel_reg ? trail : lead);
  wire din = role_select_bit_reg ? pin_sync[3] : pin_sync[2];
  wire last = sample & (bit_cnt_reg == 4'h7);
  // shift on the other edge so the data line is steady at capture;
  // phase 1 skips its first edge and shifts with its last capture instead
  wire shift = busy_reg & (clock_phase_sel_reg ? ((lead & (bit_cnt_reg != 4'h0)) | last) : trail);

  // transfer ends when clock returns idle after the eighth bit
  wire done = trail & (bit_cnt_reg == (clock_phase_sel_reg ? 4'h7 : 4'h8)); // RULE17

  // slave transfer start: select fall (phase 0) or first edge (phase 1)
  wire s_start = is_slave & ~busy_reg & (clock_phase_sel_reg ? s_lead : ss_fell); // RULE17
  wire m_start = is_master & ~busy_reg & ~tx_empty_flag_reg; // RULE1

  // conflict conditions; enable must be set to raise the flag
  wire m_conf = is_master & ~ss_s; // RULE14
  wire s_conf = is_slave & busy_reg & ss_rose; // RULE16 RULE18
  wire conf_cond = select_conflict_enable_reg & (m_conf | s_conf); // RULE13
  wire m_conf_set = select_conflict_enable_reg & m_conf & ss_fell; // RULE14
  wire conf_set = m_conf_set | (select_conflict_enable_reg & s_conf);

  // control register and master-fault disable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {role_select_bit_reg, clock_polarity_sel_reg, clock_phase_sel_reg, module_enable_reg, tx_irq_enable_reg} <=
        `CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        tx_irq_enable_reg <= pwdata[`CTRL_TX_IRQ_EN];
        module_enable_reg <= pwdata[`CTRL_MOD_EN];
        clock_phase_sel_reg <= pwdata[`CTRL_PHASE];
        clock_polarity_sel_reg <= pwdata[`CTRL_POL];
        role_select_bit_reg <= pwdata[`CTRL_ROLE];
      end
      // fault wins over a same-cycle write; role bit kept for software
      if (m_conf_set)
        module_enable_reg <= 1'b0; // RULE15 RULE20
    end
  end

  // status enables; reset only by a system reset, never by disabling
  // kept apart from control so a fault-driven disable never touches them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_irq_enable_reg <= 1'b0;
      select_conflict_enable_reg <= 1'b0;
      rx_irq_enable_reg <= 1'b0;
    end else if (wr_stat) begin
      error_irq_enable_reg <= pwdata[`STAT_ERR_IRQ_EN];
      select_conflict_enable_reg <= pwdata[`STAT_CONF_EN];
      rx_irq_enable_reg <= pwdata[2];
    end
  end

  // transfer engine: divider, bit counter, shift register, transmit buffer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      phase_reg <= 1'b0;
      div_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_buf_reg <= 8'h00;
      tx_empty_flag_reg <= 1'b1;
      sck_int_reg <= 1'b0;
      rx_bit_reg <= 1'b0;
    end else if (!module_enable_reg || m_conf_set) begin
      // partial reset: abort, clear shifter and state counter
      busy_reg <= 1'b0;
      phase_reg <= 1'b0;
      div_reg <= 8'h00;
      bit_cnt_reg <= 4'h0; // RULE15
      shift_reg <= 8'h00;
      tx_empty_flag_reg <= 1'b1; // RULE15
      sck_int_reg <= 1'b0;
      rx_bit_reg <= 1'b0;
      if (wr_data)
        tx_buf_reg <= pwdata[7:0];
    end else begin
      if (is_master & busy_reg)
        div_reg <= m_tick ? 8'h00 : div_reg + 8'h01;
      if (m_tick) begin
        phase_reg <= ~phase_reg;
        sck_int_reg <= ~sck_int_reg;
      end
      if (sample) begin
        rx_bit_reg <= din;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      // captured bit enters the shifter on the shift edge
      if (shift)
        shift_reg <= {shift_reg[6:0], sample ? din : rx_bit_reg};
      if (done || (is_slave & busy_reg & ss_rose & ~clock_phase_sel_reg)) begin
        busy_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
      end
      if (m_start | s_start)
        busy_reg <= 1'b1;
      // load while idle, the start cycle included; a running transfer defers it
      // until then the byte stays queued with tx empty low
      if (!busy_reg && !tx_empty_flag_reg && !wr_data) begin // RULE7
        shift_reg <= tx_buf_reg; // RULE5
        tx_empty_flag_reg <= 1'b1; // RULE2 RULE6
      end else if (wr_data) begin
        tx_buf_reg <= pwdata[7:0];
        tx_empty_flag_reg <= 1'b0; // RULE2
      end
    end
  end

  // receive side: buffer, full and overrun flags, two-step clears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_reg <= 8'h00;
      rx_full_flag_reg <= 1'b0;
      overrun_flag_reg <= 1'b0;
      rx_armed_reg <= 1'b0;
      ovr_armed_reg <= 1'b0;
    end else begin
      if (rd_stat) begin
        rx_armed_reg <= rx_full_flag_reg;
        ovr_armed_reg <= overrun_flag_reg;
      end
      if (rd_data) begin
        if (rx_armed_reg)
          rx_full_flag_reg <= 1'b0; // RULE4
        if (ovr_armed_reg)
          overrun_flag_reg <= 1'b0; // RULE10
        rx_armed_reg <= 1'b0;
        ovr_armed_reg <= 1'b0;
      end
      // bit one strobe is the eighth capture; set beats clear
      if (last && rx_full_flag_reg && !(rd_data && rx_armed_reg))
        overrun_flag_reg <= 1'b1; // RULE8
      if (last && !overrun_flag_reg && !(rx_full_flag_reg && !(rd_data && rx_armed_reg))) begin // RULE9
        rx_buf_reg <= {shift_reg[6:0], din}; // RULE3
        rx_full_flag_reg <= 1'b1; // RULE3
      end
    end
  end

  // select conflict flag with status-read then control-write clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_conflict_flag_reg <= 1'b0;
      conf_armed_reg <= 1'b0;
    end else begin
      if (rd_stat)
        conf_armed_reg <= select_conflict_flag_reg & ~conf_cond;
      else if (conf_cond)
        conf_armed_reg <= 1'b0; // RULE22
      if (conf_set)
        select_conflict_flag_reg <= 1'b1; // RULE13 RULE19
      else if (wr_ctrl && conf_armed_reg && !conf_cond) begin
        select_conflict_flag_reg <= 1'b0; // RULE22
        conf_armed_reg <= 1'b0;
      end
    end
  end

  // pin outputs and enables, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      // data pins follow the shifter one cycle late, like every output
      serial_clock_pin_out <= sck_int_reg ^ clock_polarity_sel_reg;
      serial_clock_pin_oe <= is_master; // RULE12
      mosi_out <= shift_reg[7];
      mosi_oe <= is_master; // RULE12
      miso_out <= shift_reg[7];
      miso_oe <= is_slave & ~ss_s; // RULE12 RULE21
    end
  end

  // interrupt requests, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
      rx_err_irq <= 1'b0;
    end else begin
      tx_irq <= tx_empty_flag_reg & tx_irq_enable_reg & module_enable_reg; // RULE23
      rx_err_irq <= (rx_full_flag_reg & rx_irq_enable_reg) |
        (error_irq_enable_reg & (overrun_flag_reg | select_conflict_flag_reg)); // RULE11
    end
  end

  // read mux; fields sit low, upper bits read zero
  reg [31:0] read_word;
  always @* begin
    read_word = 32'h0000_0000;
    if (is_hit(paddr, `CTRL_OFS)) begin
      read_word[4:0] = {role_select_bit_reg, clock_polarity_sel_reg, clock_phase_sel_reg,
        module_enable_reg, tx_irq_enable_reg};
    end else if (is_hit(paddr, `STAT_OFS)) begin
      read_word[7:0] = {rx_full_flag_reg, tx_empty_flag_reg, select_conflict_flag_reg, overrun_flag_reg,
        1'b0, rx_irq_enable_reg, select_conflict_enable_reg, error_irq_enable_reg};
    end else if (is_hit(paddr, `DATA_OFS)) begin
      read_word[7:0] = rx_buf_reg;
    end else begin
      read_word = 32'h0000_0000;
    end
  end

  // apb: one wait-free access cycle, unmapped addresses answer an error
  // read data are latched in setup so they stand through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
        prdata <= read_word;
      else
        prdata <= 32'h0000_0000;
    end
  end
endmodule // spi_buffering
`default_nettype wire

/* test/spi_buffering_properties.sv */
// bus answer and pin direction checker for the serial port block
`timescale 1ns/1ps
`default_nettype none
module spi_buffering_checker (
  // clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic select_n_in,
  input wire logic serial_clock_pin_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus timing: one wait-free access, single-cycle answer
  ready_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (psel && !penable && !(paddr[11:2] inside {10'h000, 10'h001, 10'h002}) |=> pslverr)
    else $error("unmapped access accepted");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  // sync adds latency, so the float is checked after four high samples
  miso_float_a: assert property (select_n_in [*4] |-> !miso_oe) else $error("deselected slave drives");
  pin_dir_a: assert property (!(miso_oe && serial_clock_pin_oe)) else $error("both roles drive");
  master_pins_a: assert property (serial_clock_pin_oe == mosi_oe) else $error("clock and data oe differ");
  cover property (pslverr);
  cover property ($rose(miso_oe));
  cover property ($fell(serial_clock_pin_oe));
endmodule // spi_buffering_checker
bind spi_buffering spi_buffering_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .select_n_in(select_n_in),
  .serial_clock_pin_oe(serial_clock_pin_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe));
`default_nettype wire

/* test/spi_peer.sv */
// behavioural peer slave on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_peer #(
  parameter logic [7:0] FIRST = 8'hA5
) (
  // serial lines, clock idles low
  input wire logic sck,
  input wire logic mosi,
  output wire logic miso,
  // last byte seen and byte count
  output logic [7:0] got,
  output int got_n
);
  logic [7:0] sh = FIRST;
  logic [7:0] rx = 8'h00;
  int k = 0;
  initial got = 8'h00;
  initial got_n = 0;
  // capture on the leading edge
  always @(posedge sck) rx <= {rx[6:0], mosi};
  // shift on the trailing edge; each byte echoes back next frame so stale data shows
  always @(negedge sck) begin
    if (k == 7) begin
      got <= rx;
      got_n <= got_n + 1;
      sh <= rx;
      k <= 0;
    end else begin
      sh <= {sh[6:0], ~sh[0]};
      k <= k + 1;
    end
  end
  assign miso = sh[7];
endmodule // spi_peer
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the serial port block
`timescale 1ns/1ps
`default_nettype none
`include "spi_buf_map.vh"
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sck_tb = 1'b0, sel_n = 1'b1;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, tx_irq, rx_err_irq, peer_miso;
  logic [7:0] got;
  int got_n, bad_count = 0, checked = 0;
  // wire levels from the DUT's output enables
  wire sck_w = sck_oe ? sck_out : sck_tb;
  wire mosi_w = mosi_oe ? mosi_out : 1'b1;
  wire miso_w = miso_oe ? miso_out : peer_miso;
  always #4 pclk = ~pclk;
  spi_buffering u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .select_n_in(sel_n), .tx_irq(tx_irq), .rx_err_irq(rx_err_irq));
  spi_peer u_peer (.sck(sck_w), .mosi(mosi_w), .miso(peer_miso), .got(got), .got_n(got_n));
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic give_up;
    bad_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    final_report();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // one bus transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'h0, `STAT_OFS, 32'h0);
      n++;
    end while (rd[b] !== v && n < 200);
    if (n >= 200) give_up();
  endtask
  task automatic wait_peer(input int c);
    int n;
    n = 0;
    while (got_n < c && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (got_n < c) give_up();
  endtask
  task automatic t_reset;
    apb(1'h0, `CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, `STAT_OFS, 32'h0);
    check(rd, 32'h40);
    apb(1'h1, 12'h00C, 32'hFF);
    check(32'(err), 32'h1);
    apb(1'h0, 12'h00C, 32'h0);
    check(rd, 32'h0);
    $display("reset and map test done");
  endtask
  task automatic t_master;
    apb(1'h1, `STAT_OFS, 32'h01);
    apb(1'h1, `CTRL_OFS, 32'h13);
    apb(1'h1, `DATA_OFS, 32'h3C);
    wait_stat(6, 1'h1);
    // second byte queued while the first shifts
    apb(1'h1, `DATA_OFS, 32'hC3);
    apb(1'h0, `STAT_OFS, 32'h0);
    check(rd, 32'h01);
    check(32'(tx_irq), 32'h0);
    wait_peer(1);
    check(32'(got), 32'h3C);
    wait_peer(2);
    check(32'(got), 32'hC3);
    repeat (8) @(posedge pclk);
    apb(1'h0, `STAT_OFS, 32'h0);
    check(rd, 32'hD1);
    check(32'(rx_err_irq), 32'h1);
    check(32'(tx_irq), 32'h1);
    apb(1'h0, `DATA_OFS, 32'h0);
    check(rd, 32'hA5);
    apb(1'h0, `STAT_OFS, 32'h0);
    check(rd, 32'h41);
    apb(1'h1, `DATA_OFS, 32'h81);
    wait_stat(7, 1'h1);
    apb(1'h0, `DATA_OFS, 32'h0);
    check(rd, 32'hC3);
    $display("master queue test done");
  endtask
  task automatic t_conflict;
    sel_n <= 1'h0;
    repeat (20) @(posedge pclk);
    apb(1'h0, `CTRL_OFS, 32'h0);
    check(rd, 32'h13);
    sel_n <= 1'h1;
    apb(1'h1, `STAT_OFS, 32'h03);
    sel_n <= 1'h0;
    wait_stat(5, 1'h1);
    check(rd, 32'h63);
    apb(1'h0, `CTRL_OFS, 32'h0);
    check(rd, 32'h11);
    check(32'(rx_err_irq), 32'h1);
    check(32'(sck_oe), 32'h0);
    check(32'(tx_irq), 32'h0);
    apb(1'h1, `STAT_OFS, 32'h01);
    sel_n <= 1'h1;
    repeat (8) @(posedge pclk);
    apb(1'h0, `STAT_OFS, 32'h0);
    check(rd, 32'h61);
    apb(1'h1, `CTRL_OFS, 32'h10);
    apb(1'h0, `STAT_OFS, 32'h0);
    check(rd, 32'h41);
    $display("master conflict test done");
  endtask
  task automatic t_slave;
    apb(1'h1, `STAT_OFS, 32'h02);
    apb(1'h1, `CTRL_OFS, 32'h02);
    apb(1'h1, `DATA_OFS, 32'h80);
    sel_n <= 1'h0;
    repeat (8) @(posedge pclk);
    check(32'(miso_oe), 32'h1);
    check(32'(miso_out), 32'h1);
    sel_n <= 1'h1;
    wait_stat(5, 1'h1);
    check(rd, 32'h62);
    check(32'(miso_oe), 32'h0);
    apb(1'h0, `CTRL_OFS, 32'h0);
    check(rd, 32'h02);
    // the control write after the status read clears the flag; a phase 1 select pulse alone raises none
    apb(1'h1, `CTRL_OFS, 32'h04);
    apb(1'h1, `CTRL_OFS, 32'h06);
    sel_n <= 1'h0;
    repeat (8) @(posedge pclk);
    sel_n <= 1'h1;
    repeat (8) @(posedge pclk);
    apb(1'h0, `STAT_OFS, 32'h0);
    check(rd, 32'h42);
    sel_n <= 1'h0;
    repeat (3) begin
      repeat (4) @(posedge pclk);
      sck_tb <= 1'h1;
      repeat (4) @(posedge pclk);
      sck_tb <= 1'h0;
    end
    sel_n <= 1'h1;
    wait_stat(5, 1'h1);
    check(rd, 32'h62);
    $display("slave conflict test done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_master();
    t_conflict();
    t_slave();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
